/* File: hw/dbk_pkg.sv */
package dbk_pkg;

  // Debug register addresses on the serial link
  localparam logic [7:0] DBK_ADDR_M0_LOW = 8'h00;
  localparam logic [7:0] DBK_ADDR_M0_HIGH = 8'h01;
  localparam logic [7:0] DBK_ADDR_M0_UPPER = 8'h02;
  localparam logic [7:0] DBK_ADDR_M1_LOW = 8'h03;
  localparam logic [7:0] DBK_ADDR_M1_HIGH = 8'h04;
  localparam logic [7:0] DBK_ADDR_M1_UPPER = 8'h05;
  localparam logic [7:0] DBK_ADDR_BRK_CTL = 8'h10;
  localparam logic [7:0] DBK_ADDR_WR_UPPER = 8'h13;
  localparam logic [7:0] DBK_ADDR_WR_HIGH = 8'h14;
  localparam logic [7:0] DBK_ADDR_WR_LOW = 8'h15;
  localparam logic [7:0] DBK_ADDR_ACC_CMD = 8'h16;

  // Break control field positions
  localparam int DBK_BIT_HALT_NEXT = 7;
  localparam int DBK_BIT_M0_EN = 4;
  localparam int DBK_BIT_M1_EN = 3;
  localparam int DBK_BIT_M1_PAGE = 2;
  localparam int DBK_BIT_M0_PAGE = 1;
  localparam int DBK_BIT_STEP = 0;

  // Reset values
  localparam logic [7:0] DBK_BRK_CTL_RST = 8'h00;
  localparam logic [23:0] DBK_MATCH_RST = 24'h000000;
  localparam logic [23:0] DBK_OPERAND_RST = 24'h000000;
  localparam logic [7:0] DBK_CMD_RST = 8'h00;

endpackage : dbk_pkg

/* File: hw/dbk_link_cap.sv */
`timescale 1ns/100ps
`default_nettype none

module dbk_link_cap (
  // Link side
  input wire logic i_link_clk,
  input wire logic i_rst_b,
  input wire logic i_link_wr,
  input wire logic [7:0] i_link_addr,
  input wire logic [7:0] i_link_wdata,
  // Core side
  input wire logic i_mclk,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [7:0] o_data
);

  logic [7:0] hold_addr_r;
  logic [7:0] hold_data_r;
  logic tog_r;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;

  // Capture each link write and flip the event toggle
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_addr_r <= 8'h00;
      hold_data_r <= 8'h00;
      tog_r <= 1'b0;
    end else if (i_link_wr) begin
      hold_addr_r <= i_link_addr;
      hold_data_r <= i_link_wdata;
      tog_r <= ~tog_r;
    end
  end

  // Two-stage toggle synchroniser plus edge history
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= tog_r;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Hold registers are stable once the toggle edge is seen
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wr <= 1'b0;
      o_addr <= 8'h00;
      o_data <= 8'h00;
    end else begin
      o_wr <= sync2_r ^ sync3_r;
      if (sync2_r ^ sync3_r) begin
        o_addr <= hold_addr_r;
        o_data <= hold_data_r;
      end
    end
  end

endmodule : dbk_link_cap

`default_nettype wire

/* File: hw/dbk_top.sv */
`timescale 1ns/100ps
`default_nettype none

// Contract
// - With match-0 break enabled, a CPU address equal to the full 24-bit match-0 value causes a break; disabled, never.
// - A match breaks only at an instruction boundary, so a mid-instruction match halts at that instruction's end.
// - A break sets the halt-next flag, which stays set until the debug master writes it back to zero.
// - With match-1 page mode off and match-1 break enabled, all 24 address bits must equal the match-1 value.
// - With match-1 page mode on, only address bits 23..8 are compared, so any address in the 256-byte page breaks.
// - Match-0 page mode selects a full 24-bit compare when 0 and a bits 23..8 compare when 1.
// - With step mode on, a break is raised after every executed instruction.
// - Three write-only bytes at 13h, 14h and 15h hold the upper, high and low bytes of the write operand.
// - The access command sits at 16h so operand bytes and command can go in one incrementing transfer.
// - An operation that needs fewer than 24 operand bits takes them from the least significant bytes.
// - A write to the access command immediately issues the encoded operation with the stored operand.
module dbk_top
  import dbk_pkg::*;
(
  // Clocks and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_link_clk,
  // Debug link register writes
  input wire logic i_link_wr,
  input wire logic [7:0] i_link_addr,
  input wire logic [7:0] i_link_wdata,
  // CPU bus observation
  input wire logic [23:0] i_cpu_addr,
  input wire logic i_cpu_addr_valid,
  input wire logic i_cpu_instr_start,
  input wire logic i_cpu_instr_end,
  // Break state
  output logic o_halt_next,
  output logic [7:0] o_brk_ctl,
  // Access command issue
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic [23:0] o_cmd_operand
);

  logic wr_p;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] brk_ctl_r;
  logic [23:0] match0_r;
  logic [23:0] match1_r;
  logic [23:0] operand_r;
  logic halt_r;
  logic pend_r;
  logic cmd_valid_r;
  logic [7:0] cmd_code_r;
  logic [23:0] cmd_operand_r;
  logic m0_hit;
  logic m1_hit;
  logic any_hit;
  logic hit_now;
  logic hit_late;
  logic step_brk;
  logic brk_set;
  logic ctl_wr;
  logic halt_clr;

  // Link writes cross into the core clock domain
  dbk_link_cap u_link_cap (
    .i_link_clk(i_link_clk),
    .i_rst_b(i_rst_b),
    .i_link_wr(i_link_wr),
    .i_link_addr(i_link_addr),
    .i_link_wdata(i_link_wdata),
    .i_mclk(i_mclk),
    .o_wr(wr_p),
    .o_addr(wr_addr),
    .o_data(wr_data)
  );

  assign ctl_wr = wr_p && (wr_addr == DBK_ADDR_BRK_CTL);

  // Break control register, halt-next bit kept separately
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      brk_ctl_r <= DBK_BRK_CTL_RST;
    end else if (ctl_wr) begin
      brk_ctl_r <= wr_data;
    end
  end

  // Match address registers, one byte per link write
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      match0_r <= DBK_MATCH_RST;
      match1_r <= DBK_MATCH_RST;
    end else if (wr_p) begin
      case (wr_addr)
        DBK_ADDR_M0_LOW: match0_r[7:0] <= wr_data;
        DBK_ADDR_M0_HIGH: match0_r[15:8] <= wr_data;
        DBK_ADDR_M0_UPPER: match0_r[23:16] <= wr_data;
        DBK_ADDR_M1_LOW: match1_r[7:0] <= wr_data;
        DBK_ADDR_M1_HIGH: match1_r[15:8] <= wr_data;
        DBK_ADDR_M1_UPPER: match1_r[23:16] <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Write operand bytes, upper at the lowest address
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      operand_r <= DBK_OPERAND_RST;
    end else if (wr_p) begin
      case (wr_addr)
        DBK_ADDR_WR_UPPER: operand_r[23:16] <= wr_data;
        DBK_ADDR_WR_HIGH: operand_r[15:8] <= wr_data;
        DBK_ADDR_WR_LOW: operand_r[7:0] <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Comparators, low byte dropped in page mode
  assign m0_hit = brk_ctl_r[DBK_BIT_M0_EN] && i_cpu_addr_valid &&
                  (i_cpu_addr[23:8] == match0_r[23:8]) &&
                  (brk_ctl_r[DBK_BIT_M0_PAGE] || (i_cpu_addr[7:0] == match0_r[7:0]));
  assign m1_hit = brk_ctl_r[DBK_BIT_M1_EN] && i_cpu_addr_valid &&
                  (i_cpu_addr[23:8] == match1_r[23:8]) &&
                  (brk_ctl_r[DBK_BIT_M1_PAGE] || (i_cpu_addr[7:0] == match1_r[7:0]));

  // Any enabled source may fire
  assign any_hit = m0_hit || m1_hit;

  // Hit at an instruction start breaks there, elsewhere waits for the end
  assign hit_now = any_hit && i_cpu_instr_start;
  assign hit_late = (pend_r || (any_hit && !i_cpu_instr_start)) && i_cpu_instr_end;
  assign step_brk = brk_ctl_r[DBK_BIT_STEP] && i_cpu_instr_end;
  assign brk_set = hit_now || hit_late || step_brk;
  assign halt_clr = ctl_wr && !wr_data[DBK_BIT_HALT_NEXT];

  // Mid-instruction match remembered until the boundary
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_r <= 1'b0;
    end else if (i_cpu_instr_end) begin
      pend_r <= 1'b0;
    end else if (any_hit && !i_cpu_instr_start) begin
      pend_r <= 1'b1;
    end
  end

  // Halt-next flag: break sets, master clears, set wins
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      halt_r <= 1'b0;
    end else if (brk_set) begin
      halt_r <= 1'b1;
    end else if (ctl_wr) begin
      halt_r <= wr_data[DBK_BIT_HALT_NEXT];
    end
  end

  // Access command issues at once with the stored operand
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd_valid_r <= 1'b0;
      cmd_code_r <= DBK_CMD_RST;
      cmd_operand_r <= DBK_OPERAND_RST;
    end else begin
      cmd_valid_r <= wr_p && (wr_addr == DBK_ADDR_ACC_CMD);
      if (wr_p && (wr_addr == DBK_ADDR_ACC_CMD)) begin
        cmd_code_r <= wr_data;
        cmd_operand_r <= operand_r;
      end
    end
  end

  // Outputs
  assign o_halt_next = halt_r;
  assign o_brk_ctl = {halt_r, brk_ctl_r[6:0]};
  assign o_cmd_valid = cmd_valid_r;
  assign o_cmd_code = cmd_code_r;
  assign o_cmd_operand = cmd_operand_r;

  // Checks on break and command behaviour
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  // Quiet cycle: no CPU event and no link write
  sequence s_quiet;
    !i_cpu_instr_end && !i_cpu_instr_start && !wr_p;
  endsequence

  // Full match of match 0 at an instruction start
  sequence s_m0_full;
    brk_ctl_r[DBK_BIT_M0_EN] && !brk_ctl_r[DBK_BIT_M0_PAGE] && i_cpu_addr_valid &&
    i_cpu_instr_start && (i_cpu_addr == match0_r);
  endsequence

  // Page match of match 0 with a differing low byte
  sequence s_m0_page;
    brk_ctl_r[DBK_BIT_M0_EN] && brk_ctl_r[DBK_BIT_M0_PAGE] && i_cpu_addr_valid &&
    i_cpu_instr_start && (i_cpu_addr[23:8] == match0_r[23:8]) && (i_cpu_addr[7:0] != match0_r[7:0]);
  endsequence

  // Page match of match 1
  sequence s_m1_page;
    brk_ctl_r[DBK_BIT_M1_EN] && brk_ctl_r[DBK_BIT_M1_PAGE] && i_cpu_addr_valid &&
    i_cpu_instr_start && (i_cpu_addr[23:8] == match1_r[23:8]);
  endsequence

  // Only match 1 armed, full mode, low byte differs, nothing else pending
  sequence s_m1_miss_low;
    brk_ctl_r[DBK_BIT_M1_EN] && !brk_ctl_r[DBK_BIT_M1_PAGE] && !brk_ctl_r[DBK_BIT_M0_EN] &&
    !brk_ctl_r[DBK_BIT_STEP] && !halt_r && !pend_r && !wr_p && i_cpu_addr_valid &&
    (i_cpu_addr[23:8] == match1_r[23:8]) && (i_cpu_addr[7:0] != match1_r[7:0]);
  endsequence

  // Mid-instruction hit, one cycle with no boundary, then the instruction end
  sequence s_mid_hit;
    (any_hit && !i_cpu_instr_start && !i_cpu_instr_end) ##1 (!i_cpu_instr_start && !i_cpu_instr_end) ##1
    (!i_cpu_instr_start && i_cpu_instr_end);
  endsequence

  // Flag clear, no mid-instruction match pending and no link write
  sequence s_calm;
    !halt_r && !pend_r && !wr_p;
  endsequence

  // Match 0 alone armed in full mode at an instruction start, low byte differs
  sequence s_m0_full_miss;
    brk_ctl_r[DBK_BIT_M0_EN] && !brk_ctl_r[DBK_BIT_M0_PAGE] && !brk_ctl_r[DBK_BIT_M1_EN] &&
    !brk_ctl_r[DBK_BIT_STEP] && i_cpu_addr_valid && i_cpu_instr_start && !i_cpu_instr_end &&
    (i_cpu_addr[23:8] == match0_r[23:8]) && (i_cpu_addr[7:0] != match0_r[7:0]);
  endsequence

  // Match 1 alone armed in page mode at an instruction start, page differs
  sequence s_m1_page_miss;
    brk_ctl_r[DBK_BIT_M1_EN] && brk_ctl_r[DBK_BIT_M1_PAGE] && !brk_ctl_r[DBK_BIT_M0_EN] &&
    !brk_ctl_r[DBK_BIT_STEP] && i_cpu_addr_valid && i_cpu_instr_start && !i_cpu_instr_end &&
    (i_cpu_addr[23:8] != match1_r[23:8]);
  endsequence

  // Both comparators off while the address equals match 0 at a start
  sequence s_m0_off_hit;
    !brk_ctl_r[DBK_BIT_M0_EN] && !brk_ctl_r[DBK_BIT_M1_EN] && !brk_ctl_r[DBK_BIT_STEP] &&
    i_cpu_addr_valid && i_cpu_instr_start && (i_cpu_addr == match0_r);
  endsequence

  // Step mode alone, inside an instruction
  sequence s_step_only;
    brk_ctl_r[DBK_BIT_STEP] && !brk_ctl_r[DBK_BIT_M0_EN] && !brk_ctl_r[DBK_BIT_M1_EN] && !i_cpu_instr_end;
  endsequence

  a_m0_full_brk: assert property (s_m0_full |=> halt_r)
    else $error("match 0 full compare did not break");

  a_m0_page_brk: assert property (s_m0_page |=> halt_r)
    else $error("match 0 page compare did not break");

  a_m1_page_brk: assert property (s_m1_page |=> halt_r)
    else $error("match 1 page compare did not break");

  a_m1_full_cmp: assert property (s_m1_miss_low ##0 i_cpu_instr_start ##0 !i_cpu_instr_end |=> !halt_r)
    else $error("match 1 broke with low byte differing in full mode");

  a_mid_hit_end: assert property (s_mid_hit |=> halt_r)
    else $error("mid instruction match did not halt at instruction end");

  a_mid_hit_wait: assert property ((s_quiet and (any_hit && !halt_r)) |=> !halt_r)
    else $error("mid instruction match halted before the boundary");

  a_step_brk: assert property (brk_ctl_r[DBK_BIT_STEP] && i_cpu_instr_end |=> halt_r)
    else $error("step mode did not break after instruction");

  a_halt_sticky: assert property (halt_r && !halt_clr |=> halt_r)
    else $error("halt flag dropped without a clearing write");

  a_halt_clear: assert property (halt_clr && !brk_set |=> !halt_r)
    else $error("clearing write did not release the halt flag");

  a_no_src_quiet: assert property ((brk_ctl_r[DBK_BIT_STEP] == 1'b0) && !brk_ctl_r[DBK_BIT_M0_EN] &&
    !brk_ctl_r[DBK_BIT_M1_EN] && !pend_r && !halt_r && !wr_p |=> !halt_r)
    else $error("halt flag set with every break source off");

  a_operand_upper: assert property (wr_p && (wr_addr == DBK_ADDR_WR_UPPER) |=>
    operand_r[23:16] == $past(wr_data))
    else $error("operand upper byte not stored");

  a_cmd_issue: assert property (wr_p && (wr_addr == DBK_ADDR_ACC_CMD) |=>
    o_cmd_valid && (o_cmd_code == $past(wr_data)) && (o_cmd_operand == $past(operand_r)) ##1 !o_cmd_valid)
    else $error("access command not issued once with its operand");

  a_cmd_low_byte: assert property (o_cmd_valid && !wr_p |-> o_cmd_operand[7:0] == operand_r[7:0])
    else $error("command operand low byte differs from stored low byte");

  a_m0_full_miss: assert property ((s_m0_full_miss and s_calm) |=> !halt_r)
    else $error("match 0 full compare broke with low byte differing");

  a_m1_page_miss: assert property ((s_m1_page_miss and s_calm) |=> !halt_r)
    else $error("match 1 page compare broke outside its page");

  a_m0_off_quiet: assert property ((s_m0_off_hit and s_calm) |=> !halt_r)
    else $error("disabled match 0 raised a break");

  a_m1_full_brk: assert property (brk_ctl_r[DBK_BIT_M1_EN] && !brk_ctl_r[DBK_BIT_M1_PAGE] &&
    i_cpu_addr_valid && i_cpu_instr_start && (i_cpu_addr == match1_r) |=> halt_r)
    else $error("match 1 full compare did not break");

  a_step_wait: assert property ((s_step_only and s_calm) |=> !halt_r)
    else $error("step mode broke before the instruction ended");

  a_hit_at_end: assert property (any_hit && !i_cpu_instr_start && i_cpu_instr_end |=> halt_r)
    else $error("match in the last cycle of an instruction did not halt");

  a_mid_next_end: assert property ((any_hit && !i_cpu_instr_start && !i_cpu_instr_end) ##1
    (!i_cpu_instr_start && i_cpu_instr_end) |=> halt_r)
    else $error("mid instruction match did not halt at the next end");

  a_any_hit_brk: assert property (any_hit && i_cpu_instr_start |=> halt_r)
    else $error("enabled source hit at an instruction start did not break");

  a_halt_rise_src: assert property (!halt_r && !brk_set &&
    !(ctl_wr && wr_data[DBK_BIT_HALT_NEXT]) |=> !halt_r)
    else $error("halt flag rose with no break and no setting write");

  a_halt_wr_set: assert property (ctl_wr && wr_data[DBK_BIT_HALT_NEXT] |=> halt_r)
    else $error("setting write did not raise the halt flag");

  a_operand_high: assert property (wr_p && (wr_addr == DBK_ADDR_WR_HIGH) |=>
    operand_r[15:8] == $past(wr_data))
    else $error("operand high byte not stored");

  a_operand_low: assert property (wr_p && (wr_addr == DBK_ADDR_WR_LOW) |=>
    operand_r[7:0] == $past(wr_data))
    else $error("operand low byte not stored");

  a_operand_hold: assert property (!wr_p |=> $stable(operand_r))
    else $error("operand changed without a link write");

  a_cmd_quiet: assert property (!(wr_p && (wr_addr == DBK_ADDR_ACC_CMD)) |=> !o_cmd_valid)
    else $error("command issued without a command write");

  a_cmd_hold: assert property (!(wr_p && (wr_addr == DBK_ADDR_ACC_CMD)) |=>
    $stable(o_cmd_code) && $stable(o_cmd_operand))
    else $error("command code or operand changed without a command write");

  a_match_hold: assert property (!wr_p |=> $stable(match0_r) && $stable(match1_r))
    else $error("match address changed without a link write");

endmodule : dbk_top

`default_nettype wire

/* File: dv/dbk_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module dbk_host_model (
  // Serial link master side
  output logic o_link_clk,
  output logic o_link_wr,
  output logic [7:0] o_link_addr,
  output logic [7:0] o_link_wdata
);
  // Link idles with its clock stopped
  initial begin
    o_link_clk = 1'b0;
    o_link_wr = 1'b0;
    o_link_addr = 8'h00;
    o_link_wdata = 8'h00;
  end

  // Frame of n bytes, first byte in bits 31:24, one per link clock
  task automatic send(input logic [7:0] addr, input logic [31:0] bytes, input int n);
    int i;
    begin
      #37;
      for (i = 0; i < n; i++) begin
        o_link_wr = 1'b1;
        o_link_addr = addr + i[7:0];
        o_link_wdata = bytes[31 - 8 * i -: 8];
        #40 o_link_clk = 1'b1;
        #80 o_link_clk = 1'b0;
        #40;
      end
      // Released lines show the inverse, never a stale value
      o_link_wr = 1'b0;
      o_link_addr = ~o_link_addr;
      o_link_wdata = ~o_link_wdata;
    end
  endtask : send
endmodule : dbk_host_model

`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import dbk_pkg::*;
  logic i_mclk, i_rst_b, link_clk, link_wr;
  logic [7:0] link_addr, link_wdata, brk_ctl, cmd_code, got_code;
  logic [23:0] cpu_addr, cmd_operand, got_op;
  logic cpu_valid, cpu_start, cpu_end, halt, cmd_valid;
  int n_fail = 0;
  int samples_checked = 0;
  int n_cmd = 0;

  // Core clock and time-zero inputs
  initial i_mclk = 1'b0;
  always #2.5 i_mclk = ~i_mclk;
  initial begin
    i_rst_b = 1'b0;
    cpu_addr = 24'h000000;
    cpu_valid = 1'b0;
    cpu_start = 1'b0;
    cpu_end = 1'b0;
  end

  dbk_host_model u_dbk_host_model (.o_link_clk(link_clk), .o_link_wr(link_wr), .o_link_addr(link_addr),
    .o_link_wdata(link_wdata));

  dbk_top u_dbk_top (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_link_clk(link_clk), .i_link_wr(link_wr),
    .i_link_addr(link_addr), .i_link_wdata(link_wdata), .i_cpu_addr(cpu_addr), .i_cpu_addr_valid(cpu_valid),
    .i_cpu_instr_start(cpu_start), .i_cpu_instr_end(cpu_end), .o_halt_next(halt), .o_brk_ctl(brk_ctl),
    .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code), .o_cmd_operand(cmd_operand));

  // Capture each command pulse mid-cycle, away from the edge that launches it
  always @(negedge i_mclk) begin
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      got_code = cmd_code;
      got_op = cmd_operand;
    end
  end

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    begin
      samples_checked++;
      if (got !== exp) begin
        n_fail++;
        $display("FAIL %s expected %h seen %h", name, exp, got);
      end
    end
  endtask : chk

  task automatic brk(input logic [7:0] ctl);
    begin
      u_dbk_host_model.send(DBK_ADDR_BRK_CTL, {ctl, 24'h000000}, 1);
      chk("brk_ctl", {16'h0000, ctl}, {16'h0000, brk_ctl});
    end
  endtask : brk

  task automatic set_match(input logic [7:0] base, input logic [23:0] v);
    u_dbk_host_model.send(base, {v[7:0], v[15:8], v[23:16], 8'h00}, 3);
  endtask : set_match

  // One CPU cycle, then the halt flag is judged
  task automatic cpu(input logic [23:0] a, input logic s, input logic e, input logic exp);
    begin
      @(negedge i_mclk);
      cpu_addr = a;
      cpu_valid = 1'b1;
      cpu_start = s;
      cpu_end = e;
      @(negedge i_mclk);
      cpu_valid = 1'b0;
      cpu_start = 1'b0;
      cpu_end = 1'b0;
      chk("halt_next", {23'h000000, exp}, {23'h000000, halt});
    end
  endtask : cpu

  task automatic t_match0;
    begin
      set_match(DBK_ADDR_M0_LOW, 24'h123456);
      brk(8'h00);
      cpu(24'h123456, 1'b1, 1'b0, 1'b0);
      brk(8'h10);
      cpu(24'h123457, 1'b1, 1'b0, 1'b0);
      cpu(24'h123456, 1'b1, 1'b0, 1'b1);
      repeat (20) @(negedge i_mclk);
      chk("halt_hold", 24'h000001, {23'h000000, halt});
      brk(8'h10);
      chk("halt_clear", 24'h000000, {23'h000000, halt});
      cpu(24'h123456, 1'b0, 1'b0, 1'b0);
      cpu(24'h000000, 1'b0, 1'b1, 1'b1);
      brk(8'h12);
      cpu(24'h1234ff, 1'b1, 1'b0, 1'b1);
      brk(8'h10);
      cpu(24'h1234ff, 1'b1, 1'b0, 1'b0);
    end
  endtask : t_match0

  task automatic t_match1;
    begin
      set_match(DBK_ADDR_M1_LOW, 24'habcdef);
      brk(8'h08);
      cpu(24'habcd00, 1'b1, 1'b0, 1'b0);
      cpu(24'habcdef, 1'b1, 1'b0, 1'b1);
      brk(8'h0c);
      cpu(24'habce00, 1'b1, 1'b0, 1'b0);
      cpu(24'habcd00, 1'b1, 1'b0, 1'b1);
      brk(8'h18);
      cpu(24'h123456, 1'b1, 1'b0, 1'b1);
      brk(8'h18);
      cpu(24'habcdef, 1'b1, 1'b0, 1'b1);
    end
  endtask : t_match1

  task automatic t_step;
    begin
      brk(8'h01);
      cpu(24'h000100, 1'b1, 1'b0, 1'b0);
      cpu(24'h000101, 1'b0, 1'b1, 1'b1);
      brk(8'h00);
      cpu(24'h000101, 1'b0, 1'b1, 1'b0);
    end
  endtask : t_step

  task automatic t_command;
    begin
      n_cmd = 0;
      u_dbk_host_model.send(DBK_ADDR_WR_UPPER, 32'ha53c8183, 4);
      chk("cmd_count", 24'h000001, n_cmd[23:0]);
      chk("cmd_code", 24'h000083, {16'h0000, got_code});
      chk("cmd_operand", 24'ha53c81, got_op);
      u_dbk_host_model.send(DBK_ADDR_WR_LOW, 32'h7e080000, 2);
      chk("cmd_count", 24'h000002, n_cmd[23:0]);
      chk("cmd_code", 24'h000008, {16'h0000, got_code});
      chk("cmd_low_byte", 24'h00007e, {16'h0000, got_op[7:0]});
      chk("cmd_operand", 24'ha53c7e, got_op);
    end
  endtask : t_command

  task automatic final_report;
    begin
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask : final_report

  // Main sequence
  initial begin
    repeat (5) @(negedge i_mclk);
    i_rst_b = 1'b1;
    @(negedge i_mclk);
    chk("reset_halt", 24'h000000, {23'h000000, halt});
    chk("reset_ctl", 24'h000000, {16'h0000, brk_ctl});
    chk("reset_cmd", 24'h000000, {23'h000000, cmd_valid});
    t_match0();
    t_match1();
    t_step();
    t_command();
    final_report();
  end

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule : tb_top

`default_nettype wire
